// ==== design/tmp_consts.svh ====
// register offsets, field positions and reset values of the timer/match/pwm unit
`ifndef TMP_CONSTS_SVH
`define TMP_CONSTS_SVH

// register byte offsets
`define TMP_OFF_CTRL 12'h000
`define TMP_OFF_COUNT 12'h004
`define TMP_OFF_PRESCALE 12'h008
`define TMP_OFF_PRE_COUNT 12'h00C
`define TMP_OFF_MATCH_CTRL 12'h010
`define TMP_OFF_CAPT_CTRL 12'h014
`define TMP_OFF_EXT_CTRL 12'h018
`define TMP_OFF_PWM_CTRL 12'h01C
`define TMP_OFF_LATCH 12'h020
`define TMP_OFF_IRQ_STATUS 12'h024
`define TMP_OFF_IRQ_ENABLE 12'h028
`define TMP_OFF_IRQ_CLEAR 12'h02C
`define TMP_OFF_EXT_STATE 12'h030
`define TMP_OFF_MATCH_BASE 12'h040
`define TMP_OFF_CAPT_BASE 12'h060

// control register fields
`define TMP_CTRL_EN 0
`define TMP_CTRL_CRST 1
`define TMP_CTRL_PWM 2
`define TMP_CTRL_SRC_LSB 3
`define TMP_CTRL_CSEL 5

// match control: reset at 2i, stop at 2i+1, dma enables from here
`define TMP_MCTRL_DMA_LSB 14
// pwm control: double-edge select at bit n for n of 2 and up, output enable at this base + n
`define TMP_PWM_EN_LSB 8

// reset value and bus answers
`define TMP_RST_WORD 32'h0000_0000
`define TMP_RESP_OKAY 2'h0
`define TMP_RESP_SLVERR 2'h2

`endif

// ==== design/tmp_pkg.sv ====
// types and shared helper functions of the timer/match/pwm unit
`default_nettype none
package tmp_pkg;
`include "tmp_consts.svh"

    typedef logic [31:0] tmp_word_t;
    typedef logic [11:0] tmp_addr_t;

    // action of an external match output on its match
    typedef enum logic [1:0] {TMP_EXT_KEEP, TMP_EXT_LOW, TMP_EXT_HIGH, TMP_EXT_TOGGLE} tmp_ext_act_t;

    // byte offset of entry idx of a register array
    function automatic tmp_addr_t tmp_reg_off(input tmp_addr_t base, input int idx);
        return base + tmp_addr_t'(4 * idx);
    endfunction

    // true for every mapped, word aligned address
    function automatic logic tmp_addr_ok(input tmp_addr_t a, input int n_match, input int n_cap);
        int ia;
        ia = int'(a);
        if (a[1:0] != 2'h0)
            return 1'b0;
        return (ia <= int'(`TMP_OFF_EXT_STATE))
            || (ia >= int'(`TMP_OFF_MATCH_BASE) && ia < int'(`TMP_OFF_MATCH_BASE) + 4 * n_match)
            || (ia >= int'(`TMP_OFF_CAPT_BASE) && ia < int'(`TMP_OFF_CAPT_BASE) + 4 * n_cap);
    endfunction

    // apply axi byte strobes to a stored word
    function automatic tmp_word_t tmp_strb_merge(input tmp_word_t old_v, input tmp_word_t new_v,
                                                 input logic [3:0] strb);
        tmp_word_t r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ==== design/tmp_reg_if.sv ====
// internal register access port between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface tmp_reg_if import tmp_pkg::*; ();
    logic wr_en;
    tmp_addr_t wr_addr;
    tmp_word_t wr_data;
    logic [3:0] wr_strb;
    tmp_addr_t rd_addr;
    tmp_word_t rd_data;

    modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
                   input rd_data);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
                  output rd_data);
endinterface
`default_nettype wire

// ==== design/tmp_capture.sv ====
// edge detection for the capture inputs and the external count source
`timescale 1ns/1ps
`default_nettype none
module tmp_capture import tmp_pkg::*; #(
    parameter int NUM_CAP = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_CAP-1:0] cap_in,
    input wire logic [2*NUM_CAP-1:0] cap_edge,
    input wire logic [1:0] cnt_edge,
    input wire logic cnt_sel,
    output logic [NUM_CAP-1:0] cap_evt,
    output logic cnt_evt
);
    logic [NUM_CAP-1:0] prev_q;
    logic [NUM_CAP-1:0] rise;
    logic [NUM_CAP-1:0] fall;

    // previous level, inputs already synchronous to aclk
    always_ff @(posedge aclk) begin
        if (!aresetn)
            prev_q <= '0;
        else
            prev_q <= cap_in;
    end

    assign rise = cap_in & ~prev_q;
    assign fall = ~cap_in & prev_q;

    // bit 0 of each pair selects rising, bit 1 falling, both for any edge
    always_comb begin
        for (int j = 0; j < NUM_CAP; j++) begin
            cap_evt[j] = (cap_edge[2*j] & rise[j]) | (cap_edge[2*j+1] & fall[j]);
        end
        // external count clock is one of the capture pins
        cnt_evt = (cnt_edge[0] & rise[cnt_sel]) | (cnt_edge[1] & fall[cnt_sel]);
    end
endmodule // tmp_capture
`default_nettype wire

// ==== design/tmp_axil_slave.sv ====
// axi4-lite slave front end feeding the internal register port
`timescale 1ns/1ps
`default_nettype none
module tmp_axil_slave import tmp_pkg::*; #(
    parameter int NUM_MATCH = 7,
    parameter int NUM_CAP = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tmp_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire tmp_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire tmp_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output tmp_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    tmp_reg_if.slave bus
);
    tmp_addr_t aw_addr_q;
    tmp_word_t w_data_q;
    logic [3:0] w_strb_q;
    logic aw_held_q;
    logic w_held_q;
    logic wr_fire;

    // write happens once address and data are both held and no answer pending
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign bus.wr_en = wr_fire;
    assign bus.wr_addr = aw_addr_q;
    assign bus.wr_data = w_data_q;
    assign bus.wr_strb = w_strb_q;
    // read data is looked up straight from the handshake address
    assign bus.rd_addr = s_axi_araddr;

    // write address channel, ready only while no address is held and no answer pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    // write data channel, may arrive before or after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response, unmapped addresses answer slverr and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= tmp_addr_ok(aw_addr_q, NUM_MATCH, NUM_CAP) ? `TMP_RESP_OKAY : `TMP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, data registered one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `TMP_RST_WORD;
            s_axi_rresp <= `TMP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= bus.rd_data;
            s_axi_rresp <= tmp_addr_ok(s_axi_araddr, NUM_MATCH, NUM_CAP) ? `TMP_RESP_OKAY : `TMP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // tmp_axil_slave
`default_nettype wire

// ==== design/tmp_top.sv ====
// timer/counter with prescaler, match, capture and pwm outputs behind axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "tmp_consts.svh"
module tmp_top import tmp_pkg::*; #(
    parameter int NUM_MATCH = 7,
    parameter int NUM_CAP = 2,
    parameter int NUM_EXT = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire tmp_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire tmp_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire tmp_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output tmp_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_CAP-1:0] cap_in,
    output logic [NUM_EXT-1:0] ext_match_out,
    output logic [NUM_MATCH-1:1] pwm_out,
    output logic [1:0] dma_req,
    output logic irq
);
    localparam int NS = NUM_MATCH + NUM_CAP;

    tmp_reg_if bus ();

    logic [5:0] ctrl_q;
    tmp_word_t prescale_q;
    tmp_word_t pc_q;
    tmp_word_t tc_q;
    logic [15:0] mctrl_q;
    logic [2*NUM_CAP-1:0] cctrl_q;
    logic [2*NUM_EXT-1:0] ectrl_q;
    logic [15:0] pwmctrl_q;
    logic [NUM_MATCH-1:0] latch_q;
    logic [NS-1:0] irq_en_q;
    logic [NS-1:0] irq_stat_q;
    tmp_word_t mr_q [NUM_MATCH];
    tmp_word_t mr_act_q [NUM_MATCH];
    tmp_word_t cap_q [NUM_CAP];

    logic [NUM_CAP-1:0] cap_evt;
    logic cnt_evt;
    logic src_evt;
    logic step;
    logic tick;
    logic [NUM_MATCH-1:0] hit;
    logic reset_hit;
    logic stop_hit;
    logic period_hit;
    logic [NUM_MATCH-1:1] pwm_set;
    logic [NUM_MATCH-1:1] pwm_clr;
    logic [NS-1:0] irq_clr;
    tmp_word_t rd_word;

    // true while the internal port writes the given offset
    function automatic logic wr_at(input tmp_addr_t off);
        return bus.wr_en && (bus.wr_addr == off);
    endfunction

    tmp_axil_slave #(
        .NUM_MATCH(NUM_MATCH),
        .NUM_CAP(NUM_CAP)
    ) u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .bus(bus.slave)
    );

    tmp_capture #(
        .NUM_CAP(NUM_CAP)
    ) u_capture (
        .aclk(aclk),
        .aresetn(aresetn),
        .cap_in(cap_in),
        .cap_edge(cctrl_q),
        .cnt_edge(ctrl_q[`TMP_CTRL_SRC_LSB +: 2]),
        .cnt_sel(ctrl_q[`TMP_CTRL_CSEL]),
        .cap_evt(cap_evt),
        .cnt_evt(cnt_evt)
    );

    // count step, prescale tick and match detection
    always_comb begin
        src_evt = (ctrl_q[`TMP_CTRL_SRC_LSB +: 2] == 2'h0) ? 1'b1 : cnt_evt;
        step = ctrl_q[`TMP_CTRL_EN] && !ctrl_q[`TMP_CTRL_CRST] && src_evt;
        tick = step && (pc_q == prescale_q);
        reset_hit = 1'b0;
        stop_hit = 1'b0;
        for (int i = 0; i < NUM_MATCH; i++) begin
            hit[i] = tick && (tc_q == mr_act_q[i]);
            reset_hit = reset_hit | (hit[i] & mctrl_q[2*i]);
            stop_hit = stop_hit | (hit[i] & mctrl_q[2*i+1]);
        end
        // in pwm mode match zero always closes the cycle
        period_hit = ctrl_q[`TMP_CTRL_PWM] && hit[0];
        reset_hit = reset_hit | period_hit;
    end

    // control register; a stop match clears the enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
        end else begin
            if (wr_at(`TMP_OFF_CTRL))
                ctrl_q <= 6'(tmp_strb_merge(tmp_word_t'(ctrl_q), bus.wr_data, bus.wr_strb));
            if (stop_hit)
                ctrl_q[`TMP_CTRL_EN] <= 1'b0;
        end
    end

    // prescale counter and main counter, both 32 bits
    always_ff @(posedge aclk) begin
        if (!aresetn || ctrl_q[`TMP_CTRL_CRST]) begin
            pc_q <= `TMP_RST_WORD;
            tc_q <= `TMP_RST_WORD;
        end else if (step) begin
            if (tick) begin
                pc_q <= `TMP_RST_WORD;
                if (reset_hit)
                    tc_q <= `TMP_RST_WORD;
                else if (!stop_hit)
                    tc_q <= tc_q + 32'h0000_0001;
            end else begin
                pc_q <= pc_q + 32'h0000_0001;
            end
        end
    end

    // software configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_q <= `TMP_RST_WORD;
            mctrl_q <= '0;
            cctrl_q <= '0;
            ectrl_q <= '0;
            pwmctrl_q <= '0;
            irq_en_q <= '0;
        end else begin
            if (wr_at(`TMP_OFF_PRESCALE))
                prescale_q <= tmp_strb_merge(prescale_q, bus.wr_data, bus.wr_strb);
            if (wr_at(`TMP_OFF_MATCH_CTRL))
                mctrl_q <= 16'(tmp_strb_merge(tmp_word_t'(mctrl_q), bus.wr_data, bus.wr_strb));
            if (wr_at(`TMP_OFF_CAPT_CTRL))
                cctrl_q <= (2*NUM_CAP)'(tmp_strb_merge('0, bus.wr_data, bus.wr_strb));
            if (wr_at(`TMP_OFF_EXT_CTRL))
                ectrl_q <= (2*NUM_EXT)'(tmp_strb_merge('0, bus.wr_data, bus.wr_strb));
            if (wr_at(`TMP_OFF_PWM_CTRL))
                pwmctrl_q <= 16'(tmp_strb_merge(tmp_word_t'(pwmctrl_q), bus.wr_data, bus.wr_strb));
            if (wr_at(`TMP_OFF_IRQ_ENABLE))
                irq_en_q <= NS'(tmp_strb_merge('0, bus.wr_data, bus.wr_strb));
        end
    end

    // match values as written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_MATCH; i++)
                mr_q[i] <= `TMP_RST_WORD;
        end else begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (wr_at(tmp_reg_off(`TMP_OFF_MATCH_BASE, i)))
                    mr_q[i] <= tmp_strb_merge(mr_q[i], bus.wr_data, bus.wr_strb);
            end
        end
    end

    // active match values: in pwm mode only released values move, and only at
    // the period match, so a half-updated pair never shapes a pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= '0;
            for (int i = 0; i < NUM_MATCH; i++)
                mr_act_q[i] <= `TMP_RST_WORD;
        end else begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (!ctrl_q[`TMP_CTRL_PWM])
                    mr_act_q[i] <= mr_q[i];
                else if (period_hit && latch_q[i])
                    mr_act_q[i] <= mr_q[i];
            end
            // a release written in the period cycle survives for the next one
            latch_q <= (period_hit ? '0 : latch_q)
                | (wr_at(`TMP_OFF_LATCH) ? bus.wr_data[NUM_MATCH-1:0] : '0);
        end
    end

    // set and clear conditions of each pwm output
    always_comb begin
        for (int n = 1; n < NUM_MATCH; n++) begin
            if ((n >= 2) && pwmctrl_q[n])
                pwm_set[n] = hit[n-1];
            else
                pwm_set[n] = hit[0] && (mr_act_q[n] != `TMP_RST_WORD);
            pwm_clr[n] = hit[n];
        end
    end

    // pwm outputs; fall wins a tie so a zero-width pulse stays low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= '0;
        end else begin
            for (int n = 1; n < NUM_MATCH; n++) begin
                if (!ctrl_q[`TMP_CTRL_PWM] || !pwmctrl_q[`TMP_PWM_EN_LSB + n])
                    pwm_out[n] <= 1'b0;
                else if (pwm_clr[n])
                    pwm_out[n] <= 1'b0;
                else if (pwm_set[n])
                    pwm_out[n] <= 1'b1;
            end
        end
    end

    // external match outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_match_out <= '0;
        end else begin
            for (int i = 0; i < NUM_EXT; i++) begin
                if (hit[i]) begin
                    unique case (tmp_ext_act_t'(ectrl_q[2*i +: 2]))
                        TMP_EXT_KEEP: ext_match_out[i] <= ext_match_out[i];
                        TMP_EXT_LOW: ext_match_out[i] <= 1'b0;
                        TMP_EXT_HIGH: ext_match_out[i] <= 1'b1;
                        TMP_EXT_TOGGLE: ext_match_out[i] <= ~ext_match_out[i];
                    endcase
                end
            end
        end
    end

    // one-cycle dma request pulses from matches zero and one
    always_ff @(posedge aclk) begin
        if (!aresetn)
            dma_req <= '0;
        else
            dma_req <= hit[1:0] & mctrl_q[`TMP_MCTRL_DMA_LSB +: 2];
    end

    // capture registers hold the count seen at the active edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int j = 0; j < NUM_CAP; j++)
                cap_q[j] <= `TMP_RST_WORD;
        end else begin
            for (int j = 0; j < NUM_CAP; j++) begin
                if (cap_evt[j])
                    cap_q[j] <= tc_q;
            end
        end
    end

    // write-one-to-clear bits of the status register
    always_comb begin
        irq_clr = '0;
        if (wr_at(`TMP_OFF_IRQ_CLEAR))
            irq_clr = bus.wr_data[NS-1:0];
    end

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | {cap_evt, hit};
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // read data lookup
    always_comb begin
        rd_word = `TMP_RST_WORD;
        case (bus.rd_addr)
            `TMP_OFF_CTRL: rd_word = tmp_word_t'(ctrl_q);
            `TMP_OFF_COUNT: rd_word = tc_q;
            `TMP_OFF_PRESCALE: rd_word = prescale_q;
            `TMP_OFF_PRE_COUNT: rd_word = pc_q;
            `TMP_OFF_MATCH_CTRL: rd_word = tmp_word_t'(mctrl_q);
            `TMP_OFF_CAPT_CTRL: rd_word = tmp_word_t'(cctrl_q);
            `TMP_OFF_EXT_CTRL: rd_word = tmp_word_t'(ectrl_q);
            `TMP_OFF_PWM_CTRL: rd_word = tmp_word_t'(pwmctrl_q);
            `TMP_OFF_LATCH: rd_word = tmp_word_t'(latch_q);
            `TMP_OFF_IRQ_STATUS: rd_word = tmp_word_t'(irq_stat_q);
            `TMP_OFF_IRQ_ENABLE: rd_word = tmp_word_t'(irq_en_q);
            `TMP_OFF_EXT_STATE: begin
                rd_word = tmp_word_t'(ext_match_out);
                rd_word[`TMP_PWM_EN_LSB + 1 +: NUM_MATCH-1] = pwm_out;
            end
            default: rd_word = `TMP_RST_WORD;
        endcase
        for (int i = 0; i < NUM_MATCH; i++) begin
            if (bus.rd_addr == tmp_reg_off(`TMP_OFF_MATCH_BASE, i))
                rd_word = mr_q[i];
        end
        for (int j = 0; j < NUM_CAP; j++) begin
            if (bus.rd_addr == tmp_reg_off(`TMP_OFF_CAPT_BASE, j))
                rd_word = cap_q[j];
        end
    end

    assign bus.rd_data = rd_word;
endmodule // tmp_top
`default_nettype wire

// ==== tb/tmp_asserts.sv ====
// checker: bus handshake and reset checks at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module tmp_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rl; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rl: assert property (p_rl) else $error("read answer late");
    property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rh: assert property (p_rh) else $error("read answer dropped");
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("write answer dropped");
    property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer repeated");
    property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bd: assert property (p_bd) else $error("write answer repeated");
    property p_awb; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_awb: assert property (p_awb) else $error("address taken early");
    property p_arr; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arr: assert property (p_arr) else $error("read taken early");
    property p_rst; $rose(aresetn) |-> !s_axi_awready && !irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs live at release");
endmodule // tmp_asserts
bind tmp_top tmp_asserts tmp_asserts_i (.*);
`default_nettype wire

// ==== tb/tmp_load.sv ====
// load model: counts high cycles of two pwm outputs
`timescale 1ns/1ps
`default_nettype none
module tmp_load (
    input wire logic aclk,
    input wire logic en,
    input wire logic [6:1] pwm,
    output logic [7:0] hi1,
    output logic [7:0] hi3
);
    // cleared outside the window so each measure starts at zero
    always_ff @(posedge aclk) begin
        hi1 <= en ? hi1 + 8'(pwm[1]) : 8'h00;
        hi3 <= en ? hi3 + 8'(pwm[3]) : 8'h00;
    end
endmodule // tmp_load
`default_nettype wire

// ==== tb/tmp_top_tb_top.sv ====
// bench: bus tasks, timer, capture, interrupt and pwm sequences
`timescale 1ns/1ps
`default_nettype none
module tmp_top_tb_top import tmp_pkg::*; ();
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, ld_en = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] cap_in = 2'h0, s_axi_bresp, s_axi_rresp, dma_req;
    logic [3:0] s_axi_wstrb = 4'hF, ext_match_out;
    logic [6:1] pwm_out;
    logic [7:0] hi1, hi3;
    tmp_addr_t s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    tmp_word_t s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    int err_total = 0, n_tests = 0, n_dma = 0;
    int tbl[3][3] = '{'{0, 1, 0}, '{7, 0, 0}, '{7, 1, 80}};
    tmp_top tmp_top_i (.*);
    tmp_load tmp_load_i (.aclk, .en(ld_en), .pwm(pwm_out), .hi1, .hi3);
    initial forever #2 aclk = ~aclk;
    // dma pulses summed over the run
    always @(posedge aclk) n_dma += int'(dma_req[0]) + int'(dma_req[1]);
    task automatic chk(input tmp_word_t g, input tmp_word_t e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // ready lines held high, so each task ends right at its answer
    task automatic wr(input tmp_addr_t a, input tmp_word_t v, input logic [1:0] re = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(re));
    endtask
    task automatic rd(input tmp_addr_t a, input tmp_word_t e, input logic [1:0] re = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(re));
    endtask
    // window of ten whole periods, any phase gives exact counts
    task automatic meas(input int e1);
        repeat (30) @(posedge aclk);
        ld_en <= 1'b1;
        repeat (100) @(posedge aclk);
        ld_en <= 1'b0;
        #1;
        chk(32'(hi1), e1);
        chk(32'(hi3), 60);
        @(posedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, well past the expected run
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(12'h03C, 32'h0000_0000, 2'h2);
        wr(12'h034, 8'h01, 2'h2);
        wr(12'h008, 8'h02);
        wr(12'h044, 8'h05);
        wr(12'h010, 16'hC008);
        wr(12'h018, 8'h1E);
        wr(12'h000, 8'h01);
        repeat (40) @(posedge aclk);
        rd(12'h004, 8'h05);
        rd(12'h000, 8'h00);
        rd(12'h024, 8'h7F);
        chk(32'(ext_match_out), 8'h03);
        chk(n_dma, 8'h02);
        chk(32'(irq), 8'h00);
        wr(12'h028, 8'h02);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 8'h01);
        wr(12'h02C, 8'h02);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 8'h00);
        wr(12'h014, 8'h09);
        cap_in <= 2'h3;
        repeat (4) @(posedge aclk);
        rd(12'h024, 8'hFD);
        cap_in <= 2'h0;
        repeat (4) @(posedge aclk);
        rd(12'h024, 16'h01FD);
        rd(12'h060, 8'h05);
        rd(12'h064, 8'h05);
        wr(12'h010, 8'h00);
        wr(12'h000, 8'h29);
        // three rising edges on capture pin 1 make one prescaled count
        repeat (3) begin
            cap_in <= 2'h2;
            repeat (2) @(posedge aclk);
            cap_in <= 2'h0;
            repeat (2) @(posedge aclk);
        end
        rd(12'h004, 8'h06);
        rd(12'h00C, 8'h00);
        wr(12'h040, 8'h09);
        wr(12'h044, 8'h03);
        wr(12'h048, 8'h06);
        wr(12'h04C, 8'h02);
        wr(12'h008, 8'h00);
        wr(12'h01C, 16'h0A08);
        wr(12'h020, 8'h0F);
        wr(12'h000, 8'h02);
        wr(12'h000, 8'h05);
        meas(40);
        for (int i = 0; i < 3; i++) begin
            wr(12'h044, 32'(tbl[i][0]));
            if (tbl[i][1] == 1) wr(12'h020, 8'h02);
            meas(tbl[i][2]);
        end
        tally_and_finish();
    end
endmodule // tmp_top_tb_top
`default_nettype wire
